// File: design/mcs_pkg.sv
`default_nettype none
package mcs_pkg;
    // register data width
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    // holding register addresses
    localparam logic [15:0] ADDR_FRAME_FORMAT = 16'h0FC0;
    localparam logic [15:0] ADDR_SLAVE = 16'h0FC1;
    localparam logic [15:0] ADDR_APPLY = 16'h0FC2;
    localparam logic [15:0] ADDR_RESTORE = 16'h0FC3;
    localparam logic [15:0] ADDR_PASSWORD = 16'h0FC4;
    localparam logic [15:0] ADDR_TIME = 16'h0FC5;
    localparam logic [15:0] ADDR_UNIT = 16'h0FC6;
    localparam logic [15:0] ADDR_EVENT_FIRST = 16'h0FD0;
    localparam logic [15:0] ADDR_EVENT_SECOND = 16'h0FD1;
    // value limits
    localparam logic [15:0] SLAVE_MAX = 16'h00F7;
    localparam logic [15:0] PASSWORD_MAX = 16'h1770;
    localparam logic [15:0] FORMAT_MAX = 16'h0003;
    localparam logic [15:0] FLAG_MAX = 16'h0001;
    localparam logic [15:0] TRIGGER_ON = 16'h0001;
    localparam logic [15:0] HOUR_MAX = 16'h0017;
    localparam logic [15:0] MINUTE_MAX = 16'h003B;
    localparam logic [15:0] TIME_SCALE = 16'h0064;
    // frame format codes
    localparam logic [1:0] FMT_8N2 = 2'h0;
    localparam logic [1:0] FMT_8E1 = 2'h1;
    localparam logic [1:0] FMT_8O1 = 2'h2;
    localparam logic [1:0] FMT_8N1 = 2'h3;
    // status bit masks and positions
    localparam logic [15:0] EVENT_FIRST_USED = 16'hDEC9;
    localparam logic [15:0] EVENT_SECOND_USED = 16'h00FF;
    localparam int ST1_DEFAULTS_BIT = 10;
    // values after reset
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [7:0] DEFAULT_SLAVE = 8'h01;
endpackage : mcs_pkg
`default_nettype wire

// File: design/mcs_sticky_word.sv
`default_nettype none
// one sticky event word: hardware sets, register writes only clear
module mcs_sticky_word #(
    parameter logic [15:0] USED_MASK = 16'hFFFF
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // event sets, one bit per event
    input wire logic [mcs_pkg::DATA_W-1:0] i_set,
    // clearing write: a zero bit in the data clears that bit
    input wire logic i_wr,
    input wire logic [mcs_pkg::DATA_W-1:0] i_wdata,
    // current word
    output logic [mcs_pkg::DATA_W-1:0] o_word
);
    import mcs_pkg::*;

    // stored bits
    logic [DATA_W-1:0] word_ff;
    // bits kept after a possible clear
    wire [DATA_W-1:0] kept = i_wr ? (word_ff & i_wdata) : word_ff;
    // set wins over clear, unused bits forced low
    wire [DATA_W-1:0] nxt_word = (kept | i_set) & USED_MASK;

    // word register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            word_ff <= RST_ZERO;
        end else begin
            word_ff <= nxt_word;
        end
    end

    assign o_word = word_ff;

    // a write never raises a bit without its event
    a_no_write_set: assert property (@(posedge i_clk) disable iff (i_rst)
        ((word_ff & ~$past(word_ff)) & ~$past(i_set)) == '0
        or $past(i_rst)) else $error("status bit set without event");
    // an event on a used bit always lands in the next cycle
    a_event_lands: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_set != '0) |=> ((word_ff & $past(i_set & USED_MASK)) == $past(i_set & USED_MASK)))
        else $error("event bit not set");
    // unused bits read zero
    a_unused_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (word_ff & ~USED_MASK) == '0) else $error("unused status bit high");
endmodule : mcs_sticky_word
`default_nettype wire

// File: design/mcs_regs.sv
`default_nettype none
module mcs_regs #(
    parameter logic [7:0] DEFAULT_ADDRESS = mcs_pkg::DEFAULT_SLAVE
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // holding register access from the frame decoder
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [mcs_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [mcs_pkg::DATA_W-1:0] i_reg_wdata,
    output logic [mcs_pkg::DATA_W-1:0] o_reg_rdata,
    output logic o_reg_ack,
    output logic o_reg_err,
    // meter events, one-cycle or level, same clock
    input wire logic i_ev_supply_break,
    input wire logic i_ev_rtc_reset,
    input wire logic i_ev_memory_lost,
    input wire logic i_ev_bad_settings,
    input wire logic i_ev_data_missing,
    input wire logic i_ev_board_found,
    input wire logic i_ev_board_error,
    input wire logic i_ev_char_bad,
    input wire logic i_ev_averaging,
    input wire logic [7:0] i_ev_alarm,
    // clock update from the real-time clock
    input wire logic i_rtc_load,
    input wire logic [4:0] i_rtc_hours,
    input wire logic [5:0] i_rtc_minutes,
    // active link settings
    output logic o_link_enable,
    output logic [7:0] o_link_address,
    output logic [1:0] o_link_format,
    output logic o_link_apply,
    // configuration outputs
    output logic o_defaults_load,
    output logic o_password_required,
    output logic [mcs_pkg::DATA_W-1:0] o_password,
    output logic [4:0] o_time_hours,
    output logic [5:0] o_time_minutes,
    output logic o_time_load,
    output logic o_unit_highlight
);
    import mcs_pkg::*;

    // elaboration check: the factory address must be a legal slave address
    // zero is allowed, it simply leaves the link off after reset
    if (DEFAULT_ADDRESS > SLAVE_MAX[7:0]) begin : g_bad_default
        $error("default address out of range");
    end

    // address decode
    wire sel_fmt = (i_reg_addr == ADDR_FRAME_FORMAT);
    wire sel_slave = (i_reg_addr == ADDR_SLAVE);
    wire sel_apply = (i_reg_addr == ADDR_APPLY);
    wire sel_restore = (i_reg_addr == ADDR_RESTORE);
    wire sel_pw = (i_reg_addr == ADDR_PASSWORD);
    wire sel_time = (i_reg_addr == ADDR_TIME);
    wire sel_unit = (i_reg_addr == ADDR_UNIT);
    wire sel_st1 = (i_reg_addr == ADDR_EVENT_FIRST);
    wire sel_st2 = (i_reg_addr == ADDR_EVENT_SECOND);
    wire sel_any = sel_fmt | sel_slave | sel_apply | sel_restore | sel_pw
                   | sel_time | sel_unit | sel_st1 | sel_st2;

    // range checks on written data
    wire ok_fmt = (i_reg_wdata <= FORMAT_MAX);
    wire ok_slave = (i_reg_wdata <= SLAVE_MAX);
    wire ok_flag = (i_reg_wdata <= FLAG_MAX);
    wire ok_pw = (i_reg_wdata <= PASSWORD_MAX);
    wire ok_data = sel_fmt ? ok_fmt :
                   sel_slave ? ok_slave :
                   sel_pw ? ok_pw :
                   (sel_apply | sel_restore | sel_unit) ? ok_flag : 1'b1;

    // accepted write strobes
    wire wr_ok = i_reg_wr & sel_any & ok_data;
    wire wr_fmt = wr_ok & sel_fmt;
    wire wr_slave = wr_ok & sel_slave;
    wire wr_pw = wr_ok & sel_pw;
    wire wr_time = wr_ok & sel_time;
    wire wr_unit = wr_ok & sel_unit;
    wire wr_st1 = wr_ok & sel_st1;
    wire wr_st2 = wr_ok & sel_st2;
    wire do_apply = wr_ok & sel_apply & (i_reg_wdata == TRIGGER_ON);
    wire do_restore = wr_ok & sel_restore & (i_reg_wdata == TRIGGER_ON);

    // staged and active configuration
    logic [1:0] fmt_ff;
    logic [7:0] slave_ff;
    logic [7:0] act_addr_ff;
    logic [1:0] act_fmt_ff;
    logic [DATA_W-1:0] pw_ff;
    logic [4:0] hours_ff;
    logic [5:0] minutes_ff;
    logic unit_ff;
    logic apply_ff;
    logic restore_ff;
    logic time_load_ff;

    // time split into hour and minute fields with clamping
    wire [DATA_W-1:0] wr_hours = i_reg_wdata / TIME_SCALE;
    wire [DATA_W-1:0] wr_minutes = i_reg_wdata % TIME_SCALE;
    wire [4:0] clamp_hours = (wr_hours > HOUR_MAX) ? HOUR_MAX[4:0] : wr_hours[4:0];
    wire [5:0] clamp_minutes = (wr_minutes > MINUTE_MAX) ?
                               MINUTE_MAX[5:0] : wr_minutes[5:0];
    // time read back as hhmm
    wire [DATA_W-1:0] time_value = DATA_W'({11'h000, hours_ff} * TIME_SCALE)
                                   + {10'h000, minutes_ff};

    // next values of the staged settings
    wire [1:0] nxt_fmt = do_restore ? FMT_8N2 : (wr_fmt ? i_reg_wdata[1:0] : fmt_ff);
    wire [7:0] nxt_slave = do_restore ? DEFAULT_ADDRESS :
                           (wr_slave ? i_reg_wdata[7:0] : slave_ff);
    // active address: zero write switches off at once, apply adopts staged
    wire [7:0] nxt_act_addr = (wr_slave && i_reg_wdata[7:0] == 8'h00) ? 8'h00 :
                              do_apply ? slave_ff : act_addr_ff;
    wire [1:0] nxt_act_fmt = do_apply ? fmt_ff : act_fmt_ff;
    wire [DATA_W-1:0] nxt_pw = do_restore ? RST_ZERO : (wr_pw ? i_reg_wdata : pw_ff);
    wire nxt_unit = do_restore ? 1'b0 : (wr_unit ? i_reg_wdata[0] : unit_ff);
    wire [4:0] nxt_hours = wr_time ? clamp_hours : (i_rtc_load ? i_rtc_hours : hours_ff);
    wire [5:0] nxt_minutes = wr_time ? clamp_minutes :
                             (i_rtc_load ? i_rtc_minutes : minutes_ff);

    // configuration registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fmt_ff <= FMT_8N2;
            slave_ff <= DEFAULT_ADDRESS;
            act_addr_ff <= DEFAULT_ADDRESS;
            act_fmt_ff <= FMT_8N2;
            pw_ff <= RST_ZERO;
            unit_ff <= 1'b0;
        end else begin
            fmt_ff <= nxt_fmt;
            slave_ff <= nxt_slave;
            act_addr_ff <= nxt_act_addr;
            act_fmt_ff <= nxt_act_fmt;
            pw_ff <= nxt_pw;
            unit_ff <= nxt_unit;
        end
    end

    // time and one-cycle strobes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hours_ff <= 5'h00;
            minutes_ff <= 6'h00;
            apply_ff <= 1'b0;
            restore_ff <= 1'b0;
            time_load_ff <= 1'b0;
        end else begin
            hours_ff <= nxt_hours;
            minutes_ff <= nxt_minutes;
            apply_ff <= do_apply;
            restore_ff <= do_restore;
            time_load_ff <= wr_time;
        end
    end

    // event vectors placed at their status bit positions
    wire [DATA_W-1:0] ev_first = {i_ev_supply_break, i_ev_rtc_reset, 1'b0,
                                  i_ev_memory_lost, i_ev_bad_settings,
                                  do_restore, i_ev_data_missing, 1'b0,
                                  i_ev_board_found, i_ev_board_error,
                                  2'b00, i_ev_char_bad, 2'b00, i_ev_averaging};
    wire [DATA_W-1:0] ev_second = {8'h00, i_ev_alarm};
    wire [DATA_W-1:0] st1_word;
    wire [DATA_W-1:0] st2_word;

    // first sticky status word
    mcs_sticky_word #(.USED_MASK(EVENT_FIRST_USED)) u_status_first (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_set(ev_first),
        .i_wr(wr_st1),
        .i_wdata(i_reg_wdata),
        .o_word(st1_word)
    );

    // second sticky status word
    mcs_sticky_word #(.USED_MASK(EVENT_SECOND_USED)) u_status_second (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_set(ev_second),
        .i_wr(wr_st2),
        .i_wdata(i_reg_wdata),
        .o_word(st2_word)
    );

    // read multiplexer; triggers read back as zero
    wire [DATA_W-1:0] rd_mux = sel_fmt ? {14'h0000, fmt_ff} :
                               sel_slave ? {8'h00, slave_ff} :
                               sel_pw ? pw_ff :
                               sel_time ? time_value :
                               sel_unit ? {15'h0000, unit_ff} :
                               sel_st1 ? st1_word :
                               sel_st2 ? st2_word : RST_ZERO;
    wire req = i_reg_wr | i_reg_rd;
    wire req_err = req & (~sel_any | (i_reg_wr & ~ok_data));

    // answer registers
    logic [DATA_W-1:0] rdata_ff;
    logic ack_ff;
    logic err_ff;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_ff <= RST_ZERO;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            rdata_ff <= (i_reg_rd & sel_any) ? rd_mux : RST_ZERO;
            ack_ff <= req;
            err_ff <= req_err;
        end
    end

    // outputs
    assign o_reg_rdata = rdata_ff;
    assign o_reg_ack = ack_ff;
    assign o_reg_err = err_ff;
    assign o_link_enable = (act_addr_ff != 8'h00);
    assign o_link_address = act_addr_ff;
    assign o_link_format = act_fmt_ff;
    assign o_link_apply = apply_ff;
    assign o_defaults_load = restore_ff;
    assign o_password_required = (pw_ff != RST_ZERO);
    assign o_password = pw_ff;
    assign o_time_hours = hours_ff;
    assign o_time_minutes = minutes_ff;
    assign o_time_load = time_load_ff;
    assign o_unit_highlight = unit_ff;

    // checks
    sequence s_zero_addr_write;
        i_reg_wr && sel_slave && i_reg_wdata == RST_ZERO;
    endsequence
    sequence s_apply_write;
        i_reg_wr && sel_apply && i_reg_wdata == TRIGGER_ON;
    endsequence

    // staged address never leaves the legal range
    a_slave_range: assert property (@(posedge i_clk) disable iff (i_rst)
        slave_ff <= SLAVE_MAX[7:0]) else $error("slave address out of range");
    // an address above the limit is refused and leaves the staged one alone
    a_slave_refuse: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_wr && sel_slave && !ok_slave) |=> $stable(slave_ff) && o_reg_err)
        else $error("bad slave address accepted");
    a_link_off: assert property (@(posedge i_clk) disable iff (i_rst)
        s_zero_addr_write |=> !o_link_enable) else $error("link not switched off");
    a_apply_adopts: assert property (@(posedge i_clk) disable iff (i_rst)
        s_apply_write |=> o_link_apply && o_link_address == $past(slave_ff)
        && o_link_format == $past(fmt_ff)) else $error("apply not adopted");
    a_restore_loads: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_wr && sel_restore && i_reg_wdata == TRIGGER_ON) |=> o_defaults_load
        && !o_password_required && !o_unit_highlight && st1_word[ST1_DEFAULTS_BIT]
        && slave_ff == DEFAULT_ADDRESS) else $error("defaults not loaded");
    a_restore_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_wr && sel_restore && i_reg_wdata == RST_ZERO) |=> !o_defaults_load
        && $stable(pw_ff)) else $error("restore zero changed settings");
    a_pw_flag: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_wr && sel_pw && i_reg_wdata > PASSWORD_MAX) |=> $stable(pw_ff))
        else $error("password over limit stored");
    a_time_clamp: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_wr && sel_time && i_reg_wdata / TIME_SCALE > HOUR_MAX) |=>
        o_time_hours == HOUR_MAX[4:0] ##1 1'b1) else $error("hours not clamped");
    a_minute_clamp: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_wr && sel_time && i_reg_wdata % TIME_SCALE > MINUTE_MAX) |=>
        o_time_minutes == MINUTE_MAX[5:0]) else $error("minutes not clamped");
    // time write of 23:57, one quiet cycle, then a read of the time
    sequence s_time_set;
        i_reg_wr && sel_time && i_reg_wdata == 16'h0935;
    endsequence
    sequence s_time_fetch;
        !i_reg_wr && !i_rtc_load ##1 i_reg_rd && sel_time && !i_reg_wr && !i_rtc_load;
    endsequence
    a_time_read: assert property (@(posedge i_clk) disable iff (i_rst)
        s_time_set ##1 s_time_fetch |=> o_reg_rdata == 16'h0935)
        else $error("time read back wrong");
    a_unit_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_wr && sel_unit && ok_flag) |=> o_unit_highlight == $past(i_reg_wdata[0]))
        else $error("unit highlight not updated");
    a_format_range: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_wr && sel_fmt && !ok_fmt) |=> $stable(fmt_ff) && o_reg_err)
        else $error("bad frame format accepted");
    a_supply_bit: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ev_supply_break |=> st1_word[15]) else $error("supply break not flagged");
    // every alarm event lands in the second word one cycle later
    a_alarm_lands: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ev_alarm != 8'h00) |=> (st2_word[7:0] & $past(i_ev_alarm)) == $past(i_ev_alarm))
        else $error("alarm event bit not set");
endmodule : mcs_regs
`default_nettype wire

// File: bench/mcs_master.sv
`default_nettype none
// register-port master: one strobe pulse per request, lines inverted once released
module mcs_master (
    // clock and answer
    input wire logic i_clk,
    input wire logic i_ack,
    // request lines
    output logic o_wr,
    output logic o_rd,
    output logic [15:0] o_addr,
    output logic [15:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle lines at time zero
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 16'hA5A5;
        o_wdata = 16'h5A5A;
    end
    // one request, then a bounded wait for the answer pulse
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
        output logic ok);
        int n;
        @(posedge i_clk);
        o_wr <= w;
        o_rd <= !w;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        // taken here; stale lines must not look like a request
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
        #1;
        n = 0;
        while (i_ack !== 1'b1 && n < 4) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        ok = (n < 4);
    endtask : access
endmodule : mcs_master
`default_nettype wire

// File: bench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mcs_pkg::*;
    // expected answer: error flag and read data
    typedef struct packed {logic e; logic [15:0] d;} mcs_note_t;
    mcs_note_t notes[$];
    mcs_note_t nt;
    logic i_clk, i_rst, wr, rd, ack, err, len, lap, dl, pr, tl, uh, ok, rl;
    logic [15:0] ad, wd, rdat, pw, ev;
    logic [7:0] la, ev2;
    logic [1:0] lf;
    logic [4:0] th, rh;
    logic [5:0] tm, rm;
    int n_mismatch, check_count, i, v, h, m;
    integer seed;
    // clock, 100 ns period
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    mcs_master i_mcs_master (.i_clk(i_clk), .i_ack(ack), .o_wr(wr), .o_rd(rd),
        .o_addr(ad), .o_wdata(wd));
    mcs_regs i_mcs_regs (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_ack(ack),
        .o_reg_err(err), .i_ev_supply_break(ev[15]), .i_ev_rtc_reset(ev[14]),
        .i_ev_memory_lost(ev[12]), .i_ev_bad_settings(ev[11]),
        .i_ev_data_missing(ev[9]), .i_ev_board_found(ev[7]), .i_ev_board_error(ev[6]),
        .i_ev_char_bad(ev[3]), .i_ev_averaging(ev[0]), .i_ev_alarm(ev2),
        .i_rtc_load(rl), .i_rtc_hours(rh), .i_rtc_minutes(rm), .o_link_enable(len),
        .o_link_address(la), .o_link_format(lf), .o_link_apply(lap),
        .o_defaults_load(dl), .o_password_required(pr), .o_password(pw),
        .o_time_hours(th), .o_time_minutes(tm), .o_time_load(tl),
        .o_unit_highlight(uh));
    // compare one value, report a mismatch
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
        check_count++;
        if (s !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    // note the answer, then run the bus cycle
    task automatic acc(input logic w, input logic [15:0] a, d, x, input logic e);
        notes.push_back({e, x});
        i_mcs_master.access(w, a, d, ok);
        if (!ok) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : acc
    task automatic wrr(input logic [15:0] a, d, input logic e);
        acc(1'b1, a, d, 16'h0000, e);
    endtask : wrr
    task automatic rdr(input logic [15:0] a, x);
        acc(1'b0, a, 16'h0000, x, 1'b0);
    endtask : rdr
    // one-cycle event pulses
    task automatic pev(input logic [15:0] a, input logic [7:0] b);
        @(posedge i_clk);
        ev <= a;
        ev2 <= b;
        @(posedge i_clk);
        ev <= 16'h0000;
        ev2 <= 8'h00;
    endtask : pev
    // watcher: every answer pulse takes the oldest note
    always @(posedge i_clk) begin
        if (ack === 1'b1) begin
            if (notes.size() == 0) begin
                chk("unexpected ack", 16'h0001, 16'h0000);
            end else begin
                nt = notes.pop_front();
                chk("rdata", rdat, nt.d);
                chk("err", 16'(err), 16'(nt.e));
            end
        end
    end
    // main sequence
    initial begin
        seed = 32'h9bba;
        n_mismatch = 0;
        check_count = 0;
        i_rst = 1'b1;
        ev = 16'h0000;
        ev2 = 8'h00;
        rl = 1'b0;
        rh = 5'h00;
        rm = 6'h00;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        // reset values and an unmapped place
        rdr(ADDR_SLAVE, 16'h0001);
        rdr(ADDR_FRAME_FORMAT, 16'h0000);
        rdr(ADDR_EVENT_FIRST, 16'h0000);
        rdr(ADDR_EVENT_SECOND, 16'h0000);
        acc(1'b0, 16'h0FC7, 16'h0000, 16'h0000, 1'b1);
        $display("test reset done");
        // address staged, adopted on apply, every frame format
        wrr(ADDR_SLAVE, 16'h00F8, 1'b1);
        wrr(ADDR_SLAVE, 16'h00F7, 1'b0);
        rdr(ADDR_SLAVE, 16'h00F7);
        chk("staged address", 16'(la), 16'h0001);
        for (i = 0; i < 4; i++) begin
            wrr(ADDR_FRAME_FORMAT, 16'(i), 1'b0);
            wrr(ADDR_APPLY, 16'h0001, 1'b0);
            chk("apply pulse", 16'(lap), 16'h0001);
            @(posedge i_clk);
            #1;
            chk("format", 16'(lf), 16'(i));
            chk("address", 16'(la), 16'h00F7);
        end
        wrr(ADDR_FRAME_FORMAT, 16'h0004, 1'b1);
        wrr(ADDR_APPLY, 16'h0002, 1'b1);
        wrr(ADDR_SLAVE, 16'h0000, 1'b0);
        @(posedge i_clk);
        #1;
        chk("link enable", 16'(len), 16'h0000);
        $display("test link done");
        // password and unit highlight limits
        wrr(ADDR_PASSWORD, 16'h1771, 1'b1);
        wrr(ADDR_PASSWORD, 16'h1770, 1'b0);
        chk("password", pw, 16'h1770);
        chk("password required", 16'(pr), 16'h0001);
        wrr(ADDR_PASSWORD, 16'h0000, 1'b0);
        chk("password free", 16'(pr), 16'h0000);
        wrr(ADDR_UNIT, 16'h0002, 1'b1);
        wrr(ADDR_UNIT, 16'h0001, 1'b0);
        chk("unit on", 16'(uh), 16'h0001);
        wrr(ADDR_UNIT, 16'h0000, 1'b0);
        chk("unit off", 16'(uh), 16'h0000);
        $display("test config done");
        // time clamping: three fixed values then random ones
        for (i = 0; i < 10; i++) begin
            v = (i == 0) ? 2359 : (i == 1) ? 2460 : (i == 2) ? 2357 :
                $unsigned($random(seed)) % 10000;
            h = (v / 100 > 23) ? 23 : v / 100;
            m = (v % 100 > 59) ? 59 : v % 100;
            wrr(ADDR_TIME, 16'(v), 1'b0);
            chk("time load", 16'(tl), 16'h0001);
            chk("hours", 16'(th), 16'(h));
            chk("minutes", 16'(tm), 16'(m));
            rdr(ADDR_TIME, 16'(h * 100 + m));
        end
        @(posedge i_clk);
        rl <= 1'b1;
        rh <= 5'h0C;
        rm <= 6'h1E;
        @(posedge i_clk);
        rl <= 1'b0;
        rdr(ADDR_TIME, 16'h04CE);
        $display("test time done");
        // each event alone, then all, then a partial clear and an all-ones write that clears nothing
        // only bits with an event input of their own; bit 10 comes from restore
        for (i = 0; i < 16; i++) begin
            pev(16'h0001 << i, 8'h00);
            rdr(ADDR_EVENT_FIRST, (16'h0001 << i) & 16'hDAC9);
            wrr(ADDR_EVENT_FIRST, 16'h0000, 1'b0);
        end
        pev(16'hFFFF, 8'h00);
        wrr(ADDR_EVENT_FIRST, 16'h7FFF, 1'b0);
        rdr(ADDR_EVENT_FIRST, 16'h5AC9);
        wrr(ADDR_EVENT_FIRST, 16'hFFFF, 1'b0);
        rdr(ADDR_EVENT_FIRST, 16'h5AC9);
        wrr(ADDR_EVENT_FIRST, 16'h0000, 1'b0);
        // event and clearing write taken on the same edge: the event wins
        fork
            pev(16'h8000, 8'h00);
            wrr(ADDR_EVENT_FIRST, 16'h0000, 1'b0);
        join
        rdr(ADDR_EVENT_FIRST, 16'h8000);
        wrr(ADDR_EVENT_FIRST, 16'h0000, 1'b0);
        v = $random(seed);
        pev(16'h0000, 8'(v) | 8'h01);
        rdr(ADDR_EVENT_SECOND, {8'h00, 8'(v) | 8'h01});
        wrr(ADDR_EVENT_SECOND, 16'hFF00, 1'b0);
        rdr(ADDR_EVENT_SECOND, 16'h0000);
        $display("test status done");
        // restore: zero changes nothing, one loads defaults and flags it
        wrr(ADDR_PASSWORD, 16'h0005, 1'b0);
        wrr(ADDR_RESTORE, 16'h0002, 1'b1);
        wrr(ADDR_RESTORE, 16'h0000, 1'b0);
        rdr(ADDR_PASSWORD, 16'h0005);
        wrr(ADDR_RESTORE, 16'h0001, 1'b0);
        chk("defaults load", 16'(dl), 16'h0001);
        rdr(ADDR_PASSWORD, 16'h0000);
        rdr(ADDR_SLAVE, 16'h0001);
        rdr(ADDR_EVENT_FIRST, 16'h0400);
        $display("test restore done");
        // let the last answer reach the watcher; no note may be left over
        repeat (2) @(posedge i_clk);
        chk("notes left", 16'(notes.size()), 16'h0000);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
